// ==== logic/tppl_map.vh ====
// Purpose: Constants for the touch probe position latch.
// Assumes: Register indices times four give APB byte addresses.
// Notes: Shared by the top and the channel module.
// What this block does
// - Status bit 1 or 9 sets after that probe's rising-edge latch, clear otherwise.
// - Probe 1 rising edge captures position feedback into a 32-bit value, reset zero.
// - Probe 1 falling edge captures position feedback into separate 32-bit value, reset zero.
// - Probe 2 rising edge captures position feedback into its own 32-bit value.
// - Source bit per probe: 0 digital input, 1 index pulse; status echoes it.
// - Mode bit per probe: 0 latch first edge only, 1 latch every edge.
// - Probe 2 falling edge captures position feedback into a further 32-bit value.
`ifndef TPPL_MAP_VH
`define TPPL_MAP_VH

// Register indices; byte address is index times four
`define TPPL_IDX_CTRL 18'h060B8
`define TPPL_IDX_STATUS 18'h060B9
`define TPPL_IDX_P1_RISE 18'h060BA
`define TPPL_IDX_P1_FALL 18'h060BB
`define TPPL_IDX_P2_RISE 18'h060BC
`define TPPL_IDX_P2_FALL 18'h060BD
`define TPPL_IDX_IRQ_STAT 18'h060C0
`define TPPL_IDX_IRQ_MASK 18'h060C1

// Control word layout, per-channel offset added by stride
`define TPPL_CH_STRIDE 8
`define TPPL_CTL_EN 0
`define TPPL_CTL_MODE 1
`define TPPL_CTL_SRC 2
`define TPPL_CTL_MASK 16'h0707

// Status word layout, per-channel offset added by stride
`define TPPL_ST_EN 0
`define TPPL_ST_RISE 1
`define TPPL_ST_FALL 2
`define TPPL_ST_SRC 6
`define TPPL_ST_LVL 7

// Interrupt bits: two per channel, rise then fall
`define TPPL_IRQ_W 4

// Reset values
`define TPPL_RST_CTRL 16'h0000
`define TPPL_RST_IRQ 4'h0
`define TPPL_RST_POS 32'h00000000
`define TPPL_RST_DATA 32'h00000000
`define TPPL_RST_SYNC 3'h0

// Synchroniser vector: bits 0 and 1 are the probe pins, this bit the index
`define TPPL_SYNC_IDX 2

`endif

// ==== logic/tppl_edge_latch.v ====
// Purpose: One probe channel: edge detect, arm control, position capture.
// Assumes: trig is already synchronised to core_clk; pos is same-clock data.
// Notes: Done flags clear while disabled; re-enable re-arms single mode.
`timescale 1ns/1ps
`default_nettype none
`include "tppl_map.vh"
module tppl_edge_latch #(
  parameter PW = 32
) (
  input wire core_clk,
  input wire rst_n,
  input wire enable,
  input wire cont_mode,
  input wire trig,
  input wire [PW-1:0] pos,
  output reg [PW-1:0] rise_pos_q,
  output reg [PW-1:0] fall_pos_q,
  output reg rise_done_q,
  output reg fall_done_q,
  output reg rise_evt_q,
  output reg fall_evt_q
);
  reg prev_q;
  wire rise_take;
  wire fall_take;

  // Single mode takes only the first edge of each kind until re-armed
  assign rise_take = enable & trig & ~prev_q & (cont_mode | ~rise_done_q);
  assign fall_take = enable & ~trig & prev_q & (cont_mode | ~fall_done_q);

  // Previous level tracks always, so enabling never sees a stale edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'h0;
      rise_pos_q <= `TPPL_RST_POS;
      fall_pos_q <= `TPPL_RST_POS;
      rise_done_q <= 1'h0;
      fall_done_q <= 1'h0;
      rise_evt_q <= 1'h0;
      fall_evt_q <= 1'h0;
    end else begin
      prev_q <= trig;
      rise_evt_q <= rise_take;
      fall_evt_q <= fall_take;
      if (rise_take) begin
        rise_pos_q <= pos;
      end
      if (fall_take) begin
        fall_pos_q <= pos;
      end
      // Captured values are kept on disable; only the flags drop
      if (!enable) begin
        rise_done_q <= 1'h0;
        fall_done_q <= 1'h0;
      end else begin
        if (rise_take) begin
          rise_done_q <= 1'h1;
        end
        if (fall_take) begin
          fall_done_q <= 1'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/tppl_top.v ====
// Purpose: Touch probe position latch with APB register access.
// Assumes: Probe pins and index pulse are asynchronous; pos_feedback is on core_clk.
// Notes: Zero-wait APB slave; one level interrupt from latch events.
`timescale 1ns/1ps
`default_nettype none
`include "tppl_map.vh"
module tppl_top #(
  parameter PW = 32,
  parameter AW = 20
) (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  input wire probe1_input_pin,
  input wire probe2_input_pin,
  input wire enc_index_pulse,
  input wire [PW-1:0] pos_feedback,
  output reg irq_q
);

  // Register select codes
  localparam [2:0] SEL_STATUS = 3'h0;
  localparam [2:0] SEL_P1R = 3'h1;
  localparam [2:0] SEL_P1F = 3'h2;
  localparam [2:0] SEL_P2R = 3'h3;
  localparam [2:0] SEL_P2F = 3'h4;
  localparam [2:0] SEL_CTRL = 3'h5;
  localparam [2:0] SEL_ISTAT = 3'h6;
  localparam [2:0] SEL_IMASK = 3'h7;

  // Decode a word index; bit 3 is the hit flag, low bits the select
  function [3:0] tppl_dec;
    input [AW-3:0] idx;
    begin
      case (idx)
        `TPPL_IDX_STATUS: tppl_dec = {1'h1, SEL_STATUS};
        `TPPL_IDX_P1_RISE: tppl_dec = {1'h1, SEL_P1R};
        `TPPL_IDX_P1_FALL: tppl_dec = {1'h1, SEL_P1F};
        `TPPL_IDX_P2_RISE: tppl_dec = {1'h1, SEL_P2R};
        `TPPL_IDX_P2_FALL: tppl_dec = {1'h1, SEL_P2F};
        `TPPL_IDX_CTRL: tppl_dec = {1'h1, SEL_CTRL};
        `TPPL_IDX_IRQ_STAT: tppl_dec = {1'h1, SEL_ISTAT};
        `TPPL_IDX_IRQ_MASK: tppl_dec = {1'h1, SEL_IMASK};
        default: tppl_dec = 4'h0;
      endcase
    end
  endfunction

  // Bit position of a per-channel field in the control or status word
  function integer ch_bit;
    input integer base;
    input integer ch;
    begin
      ch_bit = base + ch * `TPPL_CH_STRIDE;
    end
  endfunction

  reg [15:0] ctrl_q;
  reg [`TPPL_IRQ_W-1:0] irq_stat_q;
  reg [`TPPL_IRQ_W-1:0] irq_stat_d;
  reg [`TPPL_IRQ_W-1:0] irq_mask_q;
  reg [`TPPL_IRQ_W-1:0] irq_mask_d;
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [15:0] status_w;
  reg [31:0] rd_mux;

  wire [3:0] acc_dec;
  wire setup_ph;
  wire wr_en;
  wire wr_ctrl;
  wire wr_istat;
  wire wr_imask;
  wire [2*PW-1:0] rise_pos_w;
  wire [2*PW-1:0] fall_pos_w;
  wire [1:0] rise_done_w;
  wire [1:0] fall_done_w;
  wire [1:0] rise_evt_w;
  wire [1:0] fall_evt_w;
  wire [`TPPL_IRQ_W-1:0] evt_w;

  // Pins and index pulse come from outside; two flops before any use.
  // Bit 0 probe 1 pin, bit 1 probe 2 pin, bit 2 encoder index.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `TPPL_RST_SYNC;
      sync2_q <= `TPPL_RST_SYNC;
    end else begin
      sync1_q <= {enc_index_pulse, probe2_input_pin, probe1_input_pin};
      sync2_q <= sync1_q;
    end
  end

  // One channel per probe, each with its source choice
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ch
      wire trig_sel;
      // Switching source while enabled can itself look like an edge
      assign trig_sel = ctrl_q[ch_bit(`TPPL_CTL_SRC, g)] ? sync2_q[`TPPL_SYNC_IDX] : sync2_q[g];
      tppl_edge_latch #(
        .PW(PW)
      ) u_ch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(ctrl_q[ch_bit(`TPPL_CTL_EN, g)]),
        .cont_mode(ctrl_q[ch_bit(`TPPL_CTL_MODE, g)]),
        .trig(trig_sel),
        .pos(pos_feedback),
        .rise_pos_q(rise_pos_w[g*PW +: PW]),
        .fall_pos_q(fall_pos_w[g*PW +: PW]),
        .rise_done_q(rise_done_w[g]),
        .fall_done_q(fall_done_w[g]),
        .rise_evt_q(rise_evt_w[g]),
        .fall_evt_q(fall_evt_w[g])
      );
      assign evt_w[2*g] = rise_evt_w[g];
      assign evt_w[2*g+1] = fall_evt_w[g];
    end
  endgenerate

  // Status word assembly; unlisted bits stay zero
  integer i;
  always @* begin
    status_w = 16'h0000;
    for (i = 0; i < 2; i = i + 1) begin
      status_w[ch_bit(`TPPL_ST_EN, i)] = ctrl_q[ch_bit(`TPPL_CTL_EN, i)];
      status_w[ch_bit(`TPPL_ST_RISE, i)] = rise_done_w[i];
      status_w[ch_bit(`TPPL_ST_FALL, i)] = fall_done_w[i];
      status_w[ch_bit(`TPPL_ST_SRC, i)] = ctrl_q[ch_bit(`TPPL_CTL_SRC, i)];
      status_w[ch_bit(`TPPL_ST_LVL, i)] = sync2_q[i];
    end
  end

  // APB phase decode
  assign acc_dec = tppl_dec(paddr[AW-1:2]);
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready_q & acc_dec[3];

  // Per-register write strobes; writes to read-only words fall through
  assign wr_ctrl = wr_en & (acc_dec[2:0] == SEL_CTRL);
  assign wr_istat = wr_en & (acc_dec[2:0] == SEL_ISTAT);
  assign wr_imask = wr_en & (acc_dec[2:0] == SEL_IMASK);

  // Read data mux; narrow registers sit in the low bits
  always @* begin
    rd_mux = 32'h00000000;
    case (acc_dec[2:0])
      SEL_STATUS: rd_mux = {16'h0000, status_w};
      SEL_P1R: rd_mux = rise_pos_w[PW-1:0];
      SEL_P1F: rd_mux = fall_pos_w[PW-1:0];
      SEL_P2R: rd_mux = rise_pos_w[2*PW-1:PW];
      SEL_P2F: rd_mux = fall_pos_w[2*PW-1:PW];
      SEL_CTRL: rd_mux = {16'h0000, ctrl_q};
      SEL_ISTAT: rd_mux = {28'h0000000, irq_stat_q};
      SEL_IMASK: rd_mux = {28'h0000000, irq_mask_q};
      default: rd_mux = 32'h00000000;
    endcase
    if (!acc_dec[3]) begin
      rd_mux = 32'h00000000;
    end
  end

  // Bus answer: data sampled in setup, shown with pready in the access cycle.
  // A capture landing between the two cycles shows on the next read.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= `TPPL_RST_DATA;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~acc_dec[3];
      if (setup_ph & ~pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_istat) begin
      irq_stat_d = irq_stat_q & ~pwdata[`TPPL_IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | evt_w;
  end

  // Mask next value, so a mask write moves irq at the same edge
  always @* begin
    irq_mask_d = irq_mask_q;
    if (wr_imask) begin
      irq_mask_d = pwdata[`TPPL_IRQ_W-1:0];
    end
  end

  // Writable registers and the interrupt level
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TPPL_RST_CTRL;
      irq_stat_q <= `TPPL_RST_IRQ;
      irq_mask_q <= `TPPL_RST_IRQ;
      irq_q <= 1'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      if (wr_ctrl) begin
        ctrl_q <= pwdata[15:0] & `TPPL_CTL_MASK;
      end
      // Computed from next values so irq tracks status without extra lag
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

endmodule
`default_nettype wire

// ==== bench/tppl_checker.sv ====
// Purpose: Port checks for tppl_top
// Assumes: One clock domain, rst_n async low
// Notes: Bound from tb; only index and APB phase decode as helper logic
`timescale 1ns/1ps
`default_nettype none
`include "tppl_map.vh"
module tppl_checker #(
  parameter PW = 32,
  parameter AW = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic probe1_input_pin,
  input wire logic probe2_input_pin,
  input wire logic enc_index_pulse,
  input wire logic [PW-1:0] pos_feedback,
  input wire logic irq_q
);
  // Decode as the slave sees it, so error checks follow the map
  wire logic [AW-3:0] idx = paddr[AW-1:2];
  wire logic hit = (idx >= `TPPL_IDX_CTRL && idx <= `TPPL_IDX_P2_FALL) || idx == `TPPL_IDX_IRQ_STAT
    || idx == `TPPL_IDX_IRQ_MASK;
  wire logic setup = psel && !penable;
  wire logic rd_done = psel && penable && pready_q && !pwrite;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_after_setup: assert property (setup |=> pready_q) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_q |=> !pready_q) else $error("ready held too long");
  a_idle_quiet: assert property (!psel |=> !pready_q && !pslverr_q) else $error("answer without request");
  a_err_unmapped: assert property (setup && !hit && !pwrite |=> pslverr_q && prdata_q == 32'h00000000)
    else $error("unmapped read not refused");
  a_err_mapped_ok: assert property (setup && hit |=> !pslverr_q) else $error("error on mapped address");
  a_err_with_ready: assert property (pslverr_q |-> pready_q) else $error("error without ready");
  a_status_rsvd: assert property (rd_done && idx == `TPPL_IDX_STATUS |-> prdata_q[31:16] == 16'h0000
    && prdata_q[13:11] == 3'h0 && prdata_q[5:3] == 3'h0) else $error("reserved status bits set");
  a_ctrl_rsvd: assert property (rd_done && idx == `TPPL_IDX_CTRL |-> (prdata_q & ~32'h00000707) == 32'h0)
    else $error("reserved control bits set");
endmodule
`default_nettype wire

// ==== bench/tppl_probe_model.sv ====
// Purpose: Probe pins and index pulse seen from outside
// Assumes: Levels requested by the bench
// Notes: LAG sets how slowly the lines follow a request
`timescale 1ns/1ps
`default_nettype none
module tppl_probe_model #(
  parameter int LAG = 2
) (
  input wire logic core_clk,
  input wire logic [2:0] want,
  output logic [2:0] lines
);
  logic [2:0] pipe_q [0:7] = '{default: 3'h0};
  // Delay line; lines stay at a level, never float
  always @(posedge core_clk) begin
    pipe_q[0] <= want;
    for (int i = 1; i < 8; i++) begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign lines = pipe_q[LAG-1];
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for tppl_top
// Assumes: Zero-wait APB slave, probes via tppl_probe_model
// Notes: Positions held steady around each edge
`timescale 1ns/1ps
`default_nettype none
`include "tppl_map.vh"
module tb;
  localparam int PW = 32;
  localparam int AW = 20;
  logic core_clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] rd, a, b, c, d;
  logic er;
  logic [PW-1:0] pos_feedback = '0;
  logic [2:0] want = '0;
  wire logic [2:0] lines;
  wire logic [31:0] prdata_q;
  wire logic pready_q, pslverr_q, irq_q;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  tppl_probe_model #(.LAG(3)) tppl_probe_model_i (.core_clk(core_clk), .want(want), .lines(lines));
  tppl_top #(.PW(PW), .AW(AW)) tppl_top_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .probe1_input_pin(lines[0]), .probe2_input_pin(lines[1]),
    .enc_index_pulse(lines[2]), .pos_feedback(pos_feedback), .irq_q(irq_q));
  // Clock and cycle limit; a hang counts as a mismatch
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  function automatic logic [7:0] st_byte(input logic [2:0] ctl, input logic r, f, lvl);
    return {lvl, ctl[2], 3'h0, f, r, ctl[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [17:0] ix, input logic [31:0] wd, output logic [31:0] q,
    output logic e);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {ix, 2'h0};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready_q !== 1'b1);
    q = prdata_q;
    e = pslverr_q;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [17:0] ix, input logic [31:0] wd);
    apb(1, ix, wd, rd, er);
  endtask
  task automatic rdchk(input logic [17:0] ix, input logic [31:0] exp);
    apb(0, ix, 0, rd, er);
    chk(rd, exp);
  endtask
  // Edge pair on line n with random positions held across each edge
  task automatic pulse(input int n, output logic [31:0] pr, pf);
    pr = $urandom;
    pos_feedback <= pr;
    want[n] <= 1;
    repeat (10) @(posedge core_clk);
    pf = $urandom;
    pos_feedback <= pf;
    want[n] <= 0;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(28));
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) rdchk(18'(`TPPL_IDX_CTRL + i), 0);
    apb(0, 18'h060BE, 0, rd, er);
    chk(er, 1);
    wr(`TPPL_IDX_STATUS, 32'h0000FFFF);
    rdchk(`TPPL_IDX_STATUS, 0);
    wr(`TPPL_IDX_IRQ_MASK, 32'h0000000F);
    wr(`TPPL_IDX_CTRL, 32'h00000001);
    pulse(0, a, b);
    rdchk(`TPPL_IDX_P1_RISE, a);
    rdchk(`TPPL_IDX_P1_FALL, b);
    rdchk(`TPPL_IDX_STATUS, st_byte(3'h1, 1, 1, 0));
    chk(irq_q, 1);
    pulse(0, c, d);
    rdchk(`TPPL_IDX_P1_RISE, a);
    wr(`TPPL_IDX_IRQ_STAT, 32'h0000000F);
    repeat (2) @(posedge core_clk);
    chk(irq_q, 0);
    wr(`TPPL_IDX_CTRL, 32'h00000003);
    for (int i = 0; i < 3; i++) begin
      pulse(0, a, b);
      rdchk(`TPPL_IDX_P1_RISE, a);
    end
    wr(`TPPL_IDX_IRQ_STAT, 32'h0000000F);
    wr(`TPPL_IDX_IRQ_MASK, 32'h00000000);
    wr(`TPPL_IDX_CTRL, 32'h00000700);
    pulse(2, a, b);
    pulse(1, c, d);
    rdchk(`TPPL_IDX_P2_RISE, a);
    rdchk(`TPPL_IDX_P2_FALL, b);
    rdchk(`TPPL_IDX_STATUS, {st_byte(3'h7, 1, 1, 0), 8'h00});
    rdchk(`TPPL_IDX_IRQ_STAT, 32'h0000000C);
    chk(irq_q, 0);
    wr(`TPPL_IDX_IRQ_MASK, 32'h00000004);
    repeat (2) @(posedge core_clk);
    chk(irq_q, 1);
    want <= 3'h1;
    repeat (8) @(posedge core_clk);
    rdchk(`TPPL_IDX_STATUS, {st_byte(3'h7, 1, 1, 0), st_byte(3'h0, 0, 0, 1)});
    // Swap sources: probe 1 on the index pulse, probe 2 on its own pin
    want <= 3'h0;
    repeat (8) @(posedge core_clk);
    wr(`TPPL_IDX_CTRL, 32'h00000000);
    wr(`TPPL_IDX_CTRL, 32'h00000105);
    pulse(2, a, b);
    pulse(1, c, d);
    rdchk(`TPPL_IDX_P1_RISE, a);
    rdchk(`TPPL_IDX_P1_FALL, b);
    rdchk(`TPPL_IDX_P2_RISE, c);
    rdchk(`TPPL_IDX_P2_FALL, d);
    rdchk(`TPPL_IDX_IRQ_STAT, 32'h0000000F);
    wr(`TPPL_IDX_IRQ_STAT, 32'h00000001);
    rdchk(`TPPL_IDX_IRQ_STAT, 32'h0000000E);
    // Probe 2 pin held high: level shows, single mode refuses a repeat
    want <= 3'h2;
    repeat (8) @(posedge core_clk);
    rdchk(`TPPL_IDX_STATUS, {st_byte(3'h1, 1, 1, 1), st_byte(3'h5, 1, 1, 0)});
    rdchk(`TPPL_IDX_P2_RISE, c);
    // Mid-run reset clears captured values and control
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rdchk(`TPPL_IDX_P2_RISE, 0);
    rdchk(`TPPL_IDX_P1_FALL, 0);
    rdchk(`TPPL_IDX_CTRL, 0);
    print_verdict();
  end
endmodule
bind tppl_top tppl_checker #(.PW(PW), .AW(AW)) tppl_checker_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .probe1_input_pin(probe1_input_pin), .probe2_input_pin(probe2_input_pin),
  .enc_index_pulse(enc_index_pulse), .pos_feedback(pos_feedback), .irq_q(irq_q));
`default_nettype wire
